/* File: hdl/fdc_pkg.sv */
package fdc_pkg;
	// word layout common to all registers
	localparam int FDC_WORD_W = 24;
	localparam int FDC_SEL_W = 3;
	localparam int FDC_SEL_LSB = 0;
	// select codes
	localparam logic [2:0] FDC_SEL_INT = 3'h0;
	localparam logic [2:0] FDC_SEL_MOD = 3'h1;
	localparam logic [2:0] FDC_SEL_FRAC = 3'h2;
	localparam logic [2:0] FDC_SEL_DITH = 3'h3;
	// integer divide register fields
	localparam int FDC_RATIO_LSB = 3;
	localparam int FDC_RATIO_W = 7;
	localparam int FDC_MODE_BIT = 10;
	// modulus and numerator fields
	localparam int FDC_DEN_LSB = 3;
	localparam int FDC_DEN_W = 11;
	localparam int FDC_NUM_LSB = 3;
	localparam int FDC_NUM_W = 11;
	// dither register fields
	localparam int FDC_DEN_BIT = 3;
	localparam int FDC_RST_LSB = 4;
	localparam int FDC_RST_W = 17;
	localparam int FDC_MAG_LSB = 21;
	localparam int FDC_MAG_W = 4;
	localparam int FDC_MAG_SRC_W = 3;
	// reset values of the whole words and of the magnitude
	localparam logic [23:0] FDC_INT_RST = 24'h00_01c0;
	localparam logic [23:0] FDC_MOD_RST = 24'h00_3001;
	localparam logic [23:0] FDC_FRAC_RST = 24'h00_1802;
	localparam logic [23:0] FDC_DITH_RST = 24'h10_000b;
	localparam logic [3:0] FDC_MAG_RST = 4'hf;
	// legal whole ratio ranges
	localparam logic [6:0] FDC_INT_MIN = 7'h15;
	localparam logic [6:0] FDC_INT_MAX = 7'h7b;
	localparam logic [6:0] FDC_FRAC_MIN = 7'h18;
	localparam logic [6:0] FDC_FRAC_MAX = 7'h77;
	// decoded divider settings
	typedef struct packed {
		logic integer_mode;
		logic [6:0] whole_ratio;
		logic [10:0] denominator;
		logic [10:0] numerator;
		logic dither_en;
		logic [3:0] dither_mag;
		logic [16:0] dither_restart;
	} fdc_cfg_t;
endpackage

/* File: hdl/fdc_regs.sv */
// Functional notes
// - low three bits pick target: 0 ratio, 1 modulus, 2 numerator
// - bit 10 of ratio register: 0 fractional (default), 1 integer-only
// - integer-only mode: whole ratio legal from 21 to 123
// - fractional mode: whole ratio legal from 24 to 119
// - seven-bit ratio above select code; 21-23, 120-123 integer-only
// - eleven-bit denominator above select code, 1 to 2047, default 1536
// - select 3 loads dither register; dither enable defaults to 1
// - dither magnitude resets to 15; host may set it to 1
// - dither restart accepts 0 to 2**17-1
// - 24-bit registers loaded over three-wire serial port
`timescale 1ns/10ps
`default_nettype none
module fdc_regs
	import fdc_pkg::*;
#(
	// word and field sizes, fixed by the output struct
	parameter int P_WORD_W = FDC_WORD_W,
	parameter int P_RATIO_W = FDC_RATIO_W,
	parameter int P_DEN_W = FDC_DEN_W,
	parameter int P_NUM_W = FDC_NUM_W,
	parameter int P_RST_W = FDC_RST_W,
	parameter int P_MAG_W = FDC_MAG_W
)
(
	// system clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// three-wire serial port
	input wire logic i_sclk,
	input wire logic i_sdata,
	input wire logic i_sle,
	// divider settings
	output fdc_cfg_t o_cfg,
	output logic o_ratio_ok,
	output logic o_den_ok,
	output logic o_num_ok,
	output logic o_word_stb
);

	// elaboration checks: the output struct fixes every field size
	if (P_WORD_W != FDC_WORD_W) begin : g_bad_word
		$error("word width must be twenty-four bits");
	end
	if (P_RATIO_W != FDC_RATIO_W) begin : g_bad_ratio
		$error("ratio width must be seven bits");
	end
	if (P_DEN_W != FDC_DEN_W) begin : g_bad_den
		$error("denominator width must be eleven bits");
	end
	if (P_NUM_W != FDC_NUM_W) begin : g_bad_num
		$error("numerator width must be eleven bits");
	end
	if (P_RST_W != FDC_RST_W) begin : g_bad_rst
		$error("restart width must be seventeen bits");
	end
	if (P_MAG_W != FDC_MAG_W) begin : g_bad_mag
		$error("magnitude width must be four bits");
	end
	// the magnitude field must end inside the word
	if (FDC_MAG_LSB + FDC_MAG_SRC_W > P_WORD_W) begin : g_bad_fit
		$error("magnitude field runs past the word");
	end

	// select code match, shared by the four write strobes
	function automatic logic sel_hit(input logic [FDC_SEL_W-1:0] code,
		input logic [FDC_SEL_W-1:0] want);
		return code == want;
	endfunction

	// denominator must be nonzero
	function automatic logic den_legal(input logic [P_DEN_W-1:0] d);
		return d != '0;
	endfunction

	// numerator must stay below the denominator
	function automatic logic num_legal(input logic [P_NUM_W-1:0] n,
		input logic [P_DEN_W-1:0] d);
		return n < d;
	endfunction

	// ratio legality for the current mode
	// thresholds differ between integer-only and fractional operation
	function automatic logic ratio_legal(input logic int_mode,
		input logic [P_RATIO_W-1:0] r);
		logic ok;
		ok = 1'b0;
		if (int_mode) begin
			ok = (r >= FDC_INT_MIN) && (r <= FDC_INT_MAX);
		end else begin
			ok = (r >= FDC_FRAC_MIN) && (r <= FDC_FRAC_MAX);
		end
		return ok;
	endfunction

	// link domain: serial shifter, msb first
	// no reset: a word is taken at the latch edge, with no count of the clocked bits
	// extra leading bits fall out of the top of the shifter
	logic [P_WORD_W-1:0] shift_reg;
	logic [P_WORD_W-1:0] shift_next;
	assign shift_next = {shift_reg[P_WORD_W-2:0], i_sdata};

	always_ff @(posedge i_sclk) begin
		shift_reg <= shift_next;
	end

	// latch enable synchroniser into system domain
	// two stages guard against a metastable latch enable
	logic le_s1_reg;
	logic le_s2_reg;
	logic le_s3_reg;

	// first synchroniser stage
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			le_s1_reg <= 1'b0;
		end else begin
			le_s1_reg <= i_sle;
		end
	end

	// second synchroniser stage
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			le_s2_reg <= 1'b0;
		end else begin
			le_s2_reg <= le_s1_reg;
		end
	end

	// delayed copy for edge detection
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			le_s3_reg <= 1'b0;
		end else begin
			le_s3_reg <= le_s2_reg;
		end
	end

	// latch edge: shifter is idle while latch enable is high
	// the word crosses domains only while the serial clock stands still,
	// qualified by the synchronised edge and never read earlier
	wire le_rise;
	wire [P_WORD_W-1:0] word;
	wire [FDC_SEL_W-1:0] sel;
	assign le_rise = le_s2_reg && !le_s3_reg;
	assign word = shift_reg;
	assign sel = word[FDC_SEL_LSB +: FDC_SEL_W];

	wire wr_int;
	wire wr_mod;
	wire wr_frac;
	wire wr_dith;
	// one strobe per select code; codes four to seven match none
	assign wr_int = le_rise && sel_hit(sel, FDC_SEL_INT);
	assign wr_mod = le_rise && sel_hit(sel, FDC_SEL_MOD);
	assign wr_frac = le_rise && sel_hit(sel, FDC_SEL_FRAC);
	assign wr_dith = le_rise && sel_hit(sel, FDC_SEL_DITH);

	// stored words
	logic [FDC_WORD_W-1:0] int_reg;
	logic [FDC_WORD_W-1:0] mod_reg;
	logic [FDC_WORD_W-1:0] frac_reg;
	logic [FDC_WORD_W-1:0] dith_reg;
	logic [FDC_MAG_W-1:0] mag_reg;
	logic [FDC_WORD_W-1:0] int_next;
	logic [FDC_WORD_W-1:0] mod_next;
	logic [FDC_WORD_W-1:0] frac_next;
	logic [FDC_WORD_W-1:0] dith_next;
	logic [FDC_MAG_W-1:0] mag_next;

	// each word holds until its own select code arrives
	// other select codes leave words unchanged
	assign int_next = wr_int ? word : int_reg;
	assign mod_next = wr_mod ? word : mod_reg;
	assign frac_next = wr_frac ? word : frac_reg;
	assign dith_next = wr_dith ? word : dith_reg;
	// magnitude field, widened from its word bits
	assign mag_next = wr_dith ?
		{1'b0, word[FDC_MAG_LSB +: FDC_MAG_SRC_W]} : mag_reg;

	// ratio word with its documented default
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			int_reg <= FDC_INT_RST;
		end else begin
			int_reg <= int_next;
		end
	end

	// modulus word with its documented default
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			mod_reg <= FDC_MOD_RST;
		end else begin
			mod_reg <= mod_next;
		end
	end

	// numerator word with its documented default
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			frac_reg <= FDC_FRAC_RST;
		end else begin
			frac_reg <= frac_next;
		end
	end

	// dither word, enable set by default
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			dith_reg <= FDC_DITH_RST;
		end else begin
			dith_reg <= dith_next;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			mag_reg <= FDC_MAG_RST;
		end else begin
			mag_reg <= mag_next;
		end
	end

	// field extraction from next words
	// next words keep o_cfg in step with the strobe
	fdc_cfg_t cfg_next;
	assign cfg_next.integer_mode = int_next[FDC_MODE_BIT];
	assign cfg_next.whole_ratio = int_next[FDC_RATIO_LSB +: FDC_RATIO_W];
	assign cfg_next.denominator = mod_next[FDC_DEN_LSB +: FDC_DEN_W];
	assign cfg_next.numerator = frac_next[FDC_NUM_LSB +: FDC_NUM_W];
	assign cfg_next.dither_en = dith_next[FDC_DEN_BIT];
	assign cfg_next.dither_mag = mag_next;
	assign cfg_next.dither_restart = dith_next[FDC_RST_LSB +: FDC_RST_W];

	wire ratio_ok_next;
	wire den_ok_next;
	wire num_ok_next;
	assign ratio_ok_next = ratio_legal(cfg_next.integer_mode,
		cfg_next.whole_ratio);
	// flags report illegal values; the values are stored anyway
	// nonzero denominator
	assign den_ok_next = den_legal(cfg_next.denominator);
	assign num_ok_next = num_legal(cfg_next.numerator,
		cfg_next.denominator);

	// registered settings, cleared in reset
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_cfg <= '0;
		end else begin
			o_cfg <= cfg_next;
		end
	end

	// registered ratio flag
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_ratio_ok <= 1'b0;
		end else begin
			o_ratio_ok <= ratio_ok_next;
		end
	end

	// registered denominator flag
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_den_ok <= 1'b0;
		end else begin
			o_den_ok <= den_ok_next;
		end
	end

	// registered numerator flag
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_num_ok <= 1'b0;
		end else begin
			o_num_ok <= num_ok_next;
		end
	end

	// one-cycle strobe per latched word
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_word_stb <= 1'b0;
		end else begin
			o_word_stb <= le_rise;
		end
	end

endmodule // fdc_regs
`default_nettype wire

/* File: dv/fdc_host.sv */
`timescale 1ns/10ps
`default_nettype none
module fdc_host (
	// serial port
	output logic o_sclk,
	output logic o_sdata,
	output logic o_sle
);
	// idle lines
	initial begin
		o_sclk = 0;
		o_sdata = 0;
		o_sle = 0;
	end
	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			o_sdata = w[i];
			#3 o_sclk = 1;
			#3 o_sclk = 0;
		end
		o_sdata = ~w[0]; // data line driven to the inverse of the last bit
		#2 o_sle = 1;
		#20 o_sle = 0;
		#20;
	endtask
endmodule // fdc_host
`default_nettype wire

/* File: dv/fdc_regs_props.sv */
`timescale 1ns/10ps
`default_nettype none
module fdc_regs_props
	import fdc_pkg::*;
(
	// watched ports
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_sle,
	input wire fdc_cfg_t o_cfg,
	input wire logic o_ratio_ok,
	input wire logic o_den_ok,
	input wire logic o_num_ok,
	input wire logic o_word_stb
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	// latch then strobe
	sequence le_rise; $rose(i_sle); endsequence
	sequence stb_due; ##[2:5] o_word_stb; endsequence
	AST_STB_AFTER_LE: assert property (le_rise |-> stb_due)
		else $error("no strobe");
	AST_STB_ONE: assert property (o_word_stb |=> !o_word_stb [*3])
		else $error("long strobe");
	AST_STB_CAUSE: assert property (o_word_stb |-> $past(i_sle, 2))
		else $error("stray strobe");
	AST_HOLD: assert property ($past(i_rst_b, 2) && !o_word_stb
		|-> $stable(o_cfg)) else $error("cfg moved");
	AST_RATIO: assert property (o_ratio_ok == (o_cfg.integer_mode ?
		o_cfg.whole_ratio inside {[FDC_INT_MIN:FDC_INT_MAX]} :
		o_cfg.whole_ratio inside {[FDC_FRAC_MIN:FDC_FRAC_MAX]}))
		else $error("ratio flag");
	AST_DEN: assert property (o_den_ok == (o_cfg.denominator != 0))
		else $error("den flag");
	AST_NUM: assert property (o_num_ok == (o_cfg.numerator <
		o_cfg.denominator)) else $error("num flag");
	AST_MAG: assert property ($past(i_rst_b, 2) &&
		$changed(o_cfg.dither_mag) |-> !o_cfg.dither_mag[3])
		else $error("mag");
endmodule // fdc_regs_props
bind fdc_regs fdc_regs_props u_props (.i_mclk, .i_rst_b, .i_sle, .o_cfg,
	.o_ratio_ok, .o_den_ok, .o_num_ok, .o_word_stb);
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
	import fdc_pkg::*;
	logic i_mclk = 0, i_rst_b = 0, i_sclk, i_sdata, i_sle;
	logic o_ratio_ok, o_den_ok, o_num_ok, o_word_stb;
	fdc_cfg_t o_cfg, exp;
	int err_total = 0, total_checks = 0, cyc = 0, s;
	logic [23:0] w;
	logic [23:0] cw [8] = '{24'h00_04a8, 24'h00_03d8, 24'h00_0001,
		24'h00_3ff9, 24'h00_3ffa, 24'h20_001b, 24'hff_fffd, 24'h00_00c0};
	// clock
	always #2.5 i_mclk = ~i_mclk;
	fdc_host host (.o_sclk(i_sclk), .o_sdata(i_sdata), .o_sle(i_sle));
	fdc_regs dut (.i_mclk, .i_rst_b, .i_sclk, .i_sdata, .i_sle, .o_cfg,
		.o_ratio_ok, .o_den_ok, .o_num_ok, .o_word_stb);
	// expected store
	function automatic fdc_cfg_t nxt(fdc_cfg_t c, logic [23:0] v);
		case (v[2:0])
			FDC_SEL_INT: {c.integer_mode, c.whole_ratio} = v[10:3];
			FDC_SEL_MOD: c.denominator = v[13:3];
			FDC_SEL_FRAC: c.numerator = v[13:3];
			FDC_SEL_DITH: {c.dither_mag, c.dither_restart, c.dither_en} =
				{1'b0, v[23:3]};
			default: ;
		endcase
		return c;
	endfunction
	// expected flags
	function automatic logic [2:0] fl(fdc_cfg_t c);
		return {c.integer_mode ? c.whole_ratio inside {[21:123]} :
			c.whole_ratio inside {[24:119]}, c.denominator != 0,
			c.numerator < c.denominator};
	endfunction
	task automatic chk(logic [55:0] g, logic [55:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(logic [23:0] v);
		int n = 0;
		exp = nxt(exp, v);
		fork
			host.send(v);
			begin
				while (o_word_stb !== 1'b1 && n < 60) begin
					@(negedge i_mclk);
					n++;
				end
				chk({o_word_stb, o_cfg, o_ratio_ok, o_den_ok, o_num_ok},
					{1'b1, exp, fl(exp)});
			end
		join
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// hang guard
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			print_verdict;
		end
	end
	// main sequence
	initial begin
		void'($urandom(55));
		exp = '{1'b0, 7'h38, 11'h600, 11'h300, 1'b1, 4'hf, 17'h1_0000};
		repeat (16) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		repeat (4) @(negedge i_mclk);
		chk({1'b1, o_cfg, o_ratio_ok, o_den_ok, o_num_ok}, {1'b1, exp, 3'h7});
		for (int k = 0; k < 48; k++) begin
			s = (k < 8) ? 7 - k : $urandom_range(7);
			w = 24'($urandom);
			w[2:0] = s[2:0];
			if (s == 0) w[23:11] = '0;
			else if (s < 3) w[23:14] = '0;
			wr(k < 40 ? w : cw[k-40]);
		end
		print_verdict;
	end
endmodule // tb
`default_nettype wire
